/* rtl/acp_bus_pins.sv */
// Pin multiplexer for the four-pin bus-control port (register bits 5, 4, 3 and 0).
// Assumes strobes and area enables arrive from the bus controller on this clock.
module acp_bus_pins (
  input  wire acp_pkg::acp_mode_t  mode_class,
  input  wire logic                hw_standby,
  input  wire logic [7:0]          direction,
  input  wire logic [7:0]          data,
  input  wire logic                store_strobe_n,
  input  wire logic                read_strobe_n,
  input  wire logic                address_strobe_n,
  input  wire logic [7:0]          per_area_hold_enable,
  input  wire logic                hold_mode_select_hi,
  input  wire logic                hold_pin_level,
  output acp_pkg::acp_pins_t       pins,
  output logic                     hold_request_n
);

  logic expanded;
  logic hold_sel;

  // In the expanded modes the hold input is taken whenever any area enable bit is clear or the high mode is chosen.
  assign expanded = (mode_class != acp_pkg::ACP_SINGLE);
  assign hold_sel = expanded & ((per_area_hold_enable != acp_pkg::ALL_AREAS_ON)
                              | hold_mode_select_hi);

  // An idle bus controller sees the request line released high.
  assign hold_request_n = hold_sel ? hold_pin_level : 1'b1;

  // Strobes override direction bits; the hold pin stays an input while it is taken.
  for (genvar k = 0; k < acp_pkg::PORT_W; k++) begin : g_pin
    localparam int B = acp_pkg::acp_bus_bit(k);
    always_comb begin
      pins.out[k] = data[B];
      pins.oe[k]  = 1'b0;
      if (!hw_standby) begin
        if (!expanded) begin
          pins.oe[k] = direction[B];
        end else if (B == acp_pkg::BUS_BIT_HOLD) begin
          pins.oe[k] = direction[B] & ~hold_sel;
        end else begin
          pins.oe[k] = 1'b1;
          if (B == acp_pkg::BUS_BIT_STORE) begin
            pins.out[k] = store_strobe_n;
          end else if (B == acp_pkg::BUS_BIT_READ) begin
            pins.out[k] = read_strobe_n;
          end else begin
            pins.out[k] = address_strobe_n;
          end
        end
      end
    end
  end

endmodule : acp_bus_pins

/* rtl/acp_pkg.sv */
// Constants, types and decode helpers shared by the address and bus-control port logic.
// Assumes a single 100 MHz clock and APB register access with word-indexed addresses.
//
// Summary of operation
// - ROM-less expanded modes: upper pins drive address.
// - ROM expanded mode: direction selects address or input.
// - ROM expanded mode resets to inputs; software enables.
// - Single-chip: upper pins follow direction bits.
// - Pull-up on only if control 1, direction 0.
// - Reset, hardware standby clear pull-ups; software standby keeps.
// - ROM-less expanded modes: pull-ups always off.
// - Expanded modes: bus pins drive store, read, address strobes.
// - Expanded modes: hold pin follows direction unless hold.
// - Hold input chosen by area enables and mode select.
// - Single-chip: bus pins follow direction bits.
// - Bus direction register write-only, reads all ones.
// - Reset, hardware standby init bus direction; standby keeps.
// - Software standby: output pins keep driving.
// - Bus data read: stored if output, else pin.
// - Bus data bit 7 ignores writes, reads one.
// - Bits 6,2,1 stored; read stored or one.
// - Reset, hardware standby init bus data; standby keeps.
// - Upper data read: stored if output, else pin.
// - Upper direction initialised with high nibble set.
package acp_pkg;

  // Word indices of the registers; the APB byte address is four times the index.
  localparam int          ADDR_W           = 18;
  localparam logic [15:0] IDX_UPPER_DIR    = 16'hFFC8;
  localparam logic [15:0] IDX_BUS_DIR      = 16'hFFC9;
  localparam logic [15:0] IDX_UPPER_DATA   = 16'hFFCA;
  localparam logic [15:0] IDX_BUS_DATA     = 16'hFFCB;
  localparam logic [15:0] IDX_UPPER_PULLUP = 16'hFFDB;

  // Reset values.
  localparam logic [7:0]  UPPER_DIR_RST    = 8'hF0;
  localparam logic [7:0]  UPPER_DATA_RST   = 8'hF0;
  localparam logic [7:0]  UPPER_PULLUP_RST = 8'hF0;
  localparam logic [7:0]  BUS_DIR_RST      = 8'h80;
  localparam logic [7:0]  BUS_DATA_RST     = 8'h80;
  localparam logic [7:0]  WRITE_ONLY_READ  = 8'hFF;
  localparam logic [7:0]  ALL_AREAS_ON     = 8'hFF;
  localparam logic [3:0]  RESERVED_NIBBLE  = 4'hF;

  // Field positions of the bus-control port.
  localparam int BUS_BIT_HOLD   = 0;
  localparam int BUS_BIT_STROBE = 3;
  localparam int BUS_BIT_READ   = 4;
  localparam int BUS_BIT_STORE  = 5;
  localparam int BUS_BIT_SPARE  = 6;
  localparam int BUS_BIT_FIXED  = 7;
  localparam int PORT_W         = 4;

  // Operating mode codes on the mode pins.
  localparam logic [2:0] MODE_EXP_A   = 3'h1;
  localparam logic [2:0] MODE_EXP_B   = 3'h3;
  localparam logic [2:0] MODE_EXP_ROM = 3'h5;

  typedef enum logic [1:0] {ACP_EXP_NOROM, ACP_EXP_ROM, ACP_SINGLE} acp_mode_t;

  // Output value and enable of a four-pin port travel together.
  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
  } acp_pins_t;

  // Undefined mode codes fall back to single-chip so no pin is forced out.
  function automatic acp_mode_t acp_mode_class(input logic [2:0] mode);
    if (mode == MODE_EXP_A || mode == MODE_EXP_B) begin
      return ACP_EXP_NOROM;
    end else if (mode == MODE_EXP_ROM) begin
      return ACP_EXP_ROM;
    end else begin
      return ACP_SINGLE;
    end
  endfunction : acp_mode_class

  // Register bit that serves bus-port pin k (pins 0..3 carry bits 0, 3, 4, 5).
  function automatic int acp_bus_bit(input int k);
    return (k == 0) ? BUS_BIT_HOLD : (BUS_BIT_STROBE + k - 1);
  endfunction : acp_bus_bit

endpackage : acp_pkg

/* rtl/acp_ports.sv */
// Register file and top level of the upper-address port and the bus-control port.
// Assumes an APB master on pclk, pins sampled as synchronous inputs, and mode pins
// that are stable while the device runs. Software standby stops nothing here.
module acp_ports (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [acp_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [2:0]                    mode,
  input  wire logic                          hw_standby,
  input  wire logic [3:0]                    upper_addr,
  input  wire logic                          store_strobe_n,
  input  wire logic                          read_strobe_n,
  input  wire logic                          address_strobe_n,
  input  wire logic [7:0]                    per_area_hold_enable,
  input  wire logic                          hold_mode_select_hi,
  output logic                               hold_request_n,
  input  wire logic [3:0]                    upper_pin_in,
  output acp_pkg::acp_pins_t                 upper_pin,
  output logic [3:0]                         upper_pullup_en,
  input  wire logic [3:0]                    bus_pin_in,
  output acp_pkg::acp_pins_t                 bus_pin
);

  acp_pkg::acp_mode_t mode_class;
  logic [3:0]         upper_addr_port_direction;
  logic [3:0]         upper_addr_port_data;
  logic [3:0]         upper_addr_port_pullup_ctrl;
  logic [6:0]         bus_port_direction;
  logic [6:0]         bus_port_data;
  logic [7:0]         bus_dir_full;
  logic [7:0]         bus_data_full;
  logic [7:0]         bus_pin_level;
  logic [15:0]        index;
  logic               word_ok;
  logic               hit_upper_dir;
  logic               hit_bus_dir;
  logic               hit_upper_data;
  logic               hit_bus_data;
  logic               hit_pullup;
  logic               mapped;
  logic               wr_go;
  logic [7:0]         next_rdata;

  // Byte address is four times the word index; the low two bits must be zero.
  assign index          = paddr[acp_pkg::ADDR_W-1:2];
  assign word_ok        = (paddr[1:0] == 2'h0);
  assign hit_upper_dir  = word_ok && (index == acp_pkg::IDX_UPPER_DIR);
  assign hit_bus_dir    = word_ok && (index == acp_pkg::IDX_BUS_DIR);
  assign hit_upper_data = word_ok && (index == acp_pkg::IDX_UPPER_DATA);
  assign hit_bus_data   = word_ok && (index == acp_pkg::IDX_BUS_DATA);
  assign hit_pullup     = word_ok && (index == acp_pkg::IDX_UPPER_PULLUP);
  assign mapped         = hit_upper_dir | hit_bus_dir | hit_upper_data | hit_bus_data | hit_pullup;
  assign wr_go          = psel & penable & pwrite & mapped;

  // Every access completes in its first access cycle; unmapped ones report an error.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  assign mode_class = acp_pkg::acp_mode_class(mode);

  // Upper direction: hardware standby behaves like reset, software standby simply holds.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_addr_port_direction <= acp_pkg::UPPER_DIR_RST[3:0];
    end else if (hw_standby) begin
      upper_addr_port_direction <= acp_pkg::UPPER_DIR_RST[3:0];
    end else if (wr_go && hit_upper_dir) begin
      upper_addr_port_direction <= pwdata[3:0];
    end
  end

  // Upper data register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_addr_port_data <= acp_pkg::UPPER_DATA_RST[3:0];
    end else if (hw_standby) begin
      upper_addr_port_data <= acp_pkg::UPPER_DATA_RST[3:0];
    end else if (wr_go && hit_upper_data) begin
      upper_addr_port_data <= pwdata[3:0];
    end
  end

  // Pull-up control; clearing it turns the pull-ups off at reset and keeps them off after hardware standby.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_addr_port_pullup_ctrl <= acp_pkg::UPPER_PULLUP_RST[3:0];
    end else if (hw_standby) begin
      upper_addr_port_pullup_ctrl <= acp_pkg::UPPER_PULLUP_RST[3:0];
    end else if (wr_go && hit_pullup) begin
      upper_addr_port_pullup_ctrl <= pwdata[3:0];
    end
  end

  // Bus direction: bit 7 is not stored at all; bits 6, 2, 1 are kept only for data readback.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_port_direction <= acp_pkg::BUS_DIR_RST[6:0];
    end else if (hw_standby) begin
      bus_port_direction <= acp_pkg::BUS_DIR_RST[6:0];
    end else if (wr_go && hit_bus_dir) begin
      bus_port_direction <= pwdata[6:0];
    end
  end

  // Bus data: bit 7 is not stored and reads back as one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_port_data <= acp_pkg::BUS_DATA_RST[6:0];
    end else if (hw_standby) begin
      bus_port_data <= acp_pkg::BUS_DATA_RST[6:0];
    end else if (wr_go && hit_bus_data) begin
      bus_port_data <= pwdata[6:0];
    end
  end

  assign bus_dir_full  = {1'b1, bus_port_direction};
  assign bus_data_full = {1'b1, bus_port_data};

  // Spread the four bus pins back onto their register bit positions; unpinned bits read one.
  always_comb begin
    bus_pin_level                          = acp_pkg::WRITE_ONLY_READ;
    bus_pin_level[acp_pkg::BUS_BIT_HOLD]   = bus_pin_in[0];
    bus_pin_level[acp_pkg::BUS_BIT_STROBE] = bus_pin_in[1];
    bus_pin_level[acp_pkg::BUS_BIT_READ]   = bus_pin_in[2];
    bus_pin_level[acp_pkg::BUS_BIT_STORE]  = bus_pin_in[3];
  end

  // Read mux; output bits return the latch, input bits return the pin.
  always_comb begin
    next_rdata = 8'h00;
    if (hit_upper_dir || hit_bus_dir) begin
      next_rdata = acp_pkg::WRITE_ONLY_READ;
    end else if (hit_upper_data) begin
      next_rdata = {acp_pkg::RESERVED_NIBBLE,
                    (upper_addr_port_direction & upper_addr_port_data)
                  | (~upper_addr_port_direction & upper_pin_in)};
    end else if (hit_bus_data) begin
      next_rdata = (bus_dir_full & bus_data_full) | (~bus_dir_full & bus_pin_level);
    end else if (hit_pullup) begin
      next_rdata = {acp_pkg::RESERVED_NIBBLE, upper_addr_port_pullup_ctrl};
    end
  end

  // Read data is captured in the setup cycle so it comes from a flip-flop in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, next_rdata};
    end
  end

  acp_upper_pins u_upper (
    .mode_class  (mode_class),
    .hw_standby  (hw_standby),
    .direction   (upper_addr_port_direction),
    .data        (upper_addr_port_data),
    .pullup_ctrl (upper_addr_port_pullup_ctrl),
    .upper_addr  (upper_addr),
    .pins        (upper_pin),
    .pullup_en   (upper_pullup_en)
  );

  acp_bus_pins u_bus (
    .mode_class           (mode_class),
    .hw_standby           (hw_standby),
    .direction            (bus_dir_full),
    .data                 (bus_data_full),
    .store_strobe_n       (store_strobe_n),
    .read_strobe_n        (read_strobe_n),
    .address_strobe_n     (address_strobe_n),
    .per_area_hold_enable (per_area_hold_enable),
    .hold_mode_select_hi  (hold_mode_select_hi),
    .hold_pin_level       (bus_pin_in[0]),
    .pins                 (bus_pin),
    .hold_request_n       (hold_request_n)
  );

endmodule : acp_ports

/* rtl/acp_upper_pins.sv */
// Pin multiplexer for the four-pin upper-address port.
// Assumes register values come from flip-flops in the parent; the upper address is passed straight from its input port.
module acp_upper_pins (
  input  wire acp_pkg::acp_mode_t  mode_class,
  input  wire logic                hw_standby,
  input  wire logic [3:0]          direction,
  input  wire logic [3:0]          data,
  input  wire logic [3:0]          pullup_ctrl,
  input  wire logic [3:0]          upper_addr,
  output acp_pkg::acp_pins_t       pins,
  output logic [3:0]               pullup_en
);

  // Each pin is decided on its own; hardware standby floats every pin.
  for (genvar k = 0; k < acp_pkg::PORT_W; k++) begin : g_pin
    always_comb begin
      pins.out[k]  = data[k];
      pins.oe[k]   = 1'b0;
      pullup_en[k] = 1'b0;
      if (!hw_standby) begin
        case (mode_class)
          acp_pkg::ACP_EXP_NOROM: begin
            pins.out[k] = upper_addr[k];
            pins.oe[k]  = 1'b1;
          end
          acp_pkg::ACP_EXP_ROM: begin
            pins.out[k]  = upper_addr[k];
            pins.oe[k]   = direction[k];
            pullup_en[k] = pullup_ctrl[k] & ~direction[k];
          end
          default: begin
            pins.oe[k]   = direction[k];
            pullup_en[k] = pullup_ctrl[k] & ~direction[k];
          end
        endcase
      end
    end
  end

  // Pull-ups in the ROM-less expanded modes never leave the default off above.

endmodule : acp_upper_pins

/* test/acp_pin_model.sv */
// Model of the external pins: devices behind both four-pin ports, pull-ups behind the upper port only.
// Assumes the bench supplies the level an external device shows on a released pin.
module acp_pin_model (
  input  wire acp_pkg::acp_pins_t upper_pin,
  input  wire logic [3:0]         upper_pullup_en,
  input  wire acp_pkg::acp_pins_t bus_pin,
  input  wire logic [3:0]         ext_up,
  input  wire logic [3:0]         ext_bus,
  output logic [3:0]              upper_pin_in,
  output logic [3:0]              bus_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pin shows its driver; a released pin reads high while its pull-up is on.
  assign upper_pin_in = (upper_pin.oe & upper_pin.out) | (~upper_pin.oe & (upper_pullup_en | ext_up));
  // The external device only reaches a bus pin that the port has released.
  assign bus_pin_in = (bus_pin.oe & bus_pin.out) | (~bus_pin.oe & ext_bus);
endmodule : acp_pin_model

/* test/acp_ports_monitor.sv */
// Concurrent checks on the pin multiplexing and register reads of the port block.
// Assumes it is bound to the top module and sees only its ports.
module acp_ports_monitor (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [acp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                prdata,
  input wire logic                       pslverr,
  input wire logic [2:0]                 mode,
  input wire logic                       hw_standby,
  input wire logic [3:0]                 upper_addr,
  input wire logic                       store_strobe_n,
  input wire logic                       read_strobe_n,
  input wire logic                       address_strobe_n,
  input wire logic [7:0]                 per_area_hold_enable,
  input wire logic                       hold_mode_select_hi,
  input wire logic                       hold_request_n,
  input wire acp_pkg::acp_pins_t         upper_pin,
  input wire logic [3:0]                 upper_pullup_en,
  input wire logic [3:0]                 bus_pin_in,
  input wire acp_pkg::acp_pins_t         bus_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic noro, expd, hsel, rd;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mode decode kept apart from the design so a wrong decode there shows up.
  assign noro = (mode == acp_pkg::MODE_EXP_A) || (mode == acp_pkg::MODE_EXP_B);
  assign expd = noro || (mode == acp_pkg::MODE_EXP_ROM);
  // Hold selection does not depend on standby: a floated pin still feeds the request line.
  assign hsel = expd && (per_area_hold_enable != 8'hFF || hold_mode_select_hi);
  assign rd   = psel && penable && !pwrite;
  addr_all_out_a: assert property (noro && !hw_standby |-> upper_pin.oe == 4'hF && upper_pin.out == upper_addr)
    else $error("upper port not driving the address");
  rom_addr_out_a: assert property (mode == acp_pkg::MODE_EXP_ROM |-> ((upper_pin.out ^ upper_addr) & upper_pin.oe) == 4'h0)
    else $error("driven upper pin differs from address");
  pullup_input_a: assert property ((upper_pullup_en & upper_pin.oe) == 4'h0)
    else $error("pull-up on at an output pin");
  norom_pullup_a: assert property (noro |-> upper_pullup_en == 4'h0)
    else $error("pull-up on in a ROM-less mode");
  standby_exit_a: assert property (hw_standby ##1 !hw_standby |-> upper_pullup_en == 4'h0 && $past(upper_pullup_en) == 4'h0)
    else $error("pull-up survived hardware standby");
  strobe_pins_a: assert property (expd && !hw_standby |-> bus_pin.oe[3:1] == 3'h7 &&
    bus_pin.out[3:1] == {store_strobe_n, read_strobe_n, address_strobe_n})
    else $error("bus strobes not on their pins");
  hold_select_a: assert property (hsel ? (!bus_pin.oe[0] && hold_request_n == bus_pin_in[0]) : hold_request_n)
    else $error("hold input selection wrong");
  dir_reads_ones_a: assert property (rd && paddr == {acp_pkg::IDX_BUS_DIR, 2'b00} |-> prdata == 32'h000000FF)
    else $error("direction register read not all ones");
  data_bit7_a: assert property (rd && paddr == {acp_pkg::IDX_BUS_DATA, 2'b00} |-> prdata[7])
    else $error("bus data bit 7 read as zero");
endmodule : acp_ports_monitor

/* test/acp_ports_tb_top.sv */
// Self-checking bench for the port block: APB register access and pin checks.
// Assumes the pin model as far side and the checker bound below.
module acp_ports_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hw_standby = 1'b0;
  logic store_strobe_n = 1'b0, read_strobe_n = 1'b1, address_strobe_n = 1'b0, hold_mode_select_hi = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, hold_request_n;
  logic [2:0] mode = 3'h7;
  logic [3:0] upper_addr = 4'h9, ext_up = 4'h0, ext_bus = 4'hA, upper_pin_in, upper_pullup_en, bus_pin_in;
  logic [7:0] per_area_hold_enable = 8'hFF;
  acp_pkg::acp_pins_t upper_pin, bus_pin;
  int num_errors = 0, checks_done = 0;
  localparam logic [17:0] UD = {acp_pkg::IDX_UPPER_DIR, 2'b00}, BD = {acp_pkg::IDX_BUS_DIR, 2'b00};
  localparam logic [17:0] UR = {acp_pkg::IDX_UPPER_DATA, 2'b00}, BR = {acp_pkg::IDX_BUS_DATA, 2'b00};
  localparam logic [17:0] PU = {acp_pkg::IDX_UPPER_PULLUP, 2'b00};
  always #5 pclk = ~pclk;
  acp_ports u_acp_ports (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(mode),
    .hw_standby(hw_standby), .upper_addr(upper_addr), .store_strobe_n(store_strobe_n),
    .read_strobe_n(read_strobe_n), .address_strobe_n(address_strobe_n),
    .per_area_hold_enable(per_area_hold_enable), .hold_mode_select_hi(hold_mode_select_hi),
    .hold_request_n(hold_request_n), .upper_pin_in(upper_pin_in), .upper_pin(upper_pin),
    .upper_pullup_en(upper_pullup_en), .bus_pin_in(bus_pin_in), .bus_pin(bus_pin));
  acp_pin_model u_acp_pin_model (.upper_pin(upper_pin), .upper_pullup_en(upper_pullup_en), .bus_pin(bus_pin),
    .ext_up(ext_up), .ext_bus(ext_bus), .upper_pin_in(upper_pin_in), .bus_pin_in(bus_pin_in));
  // Expected bus data read: bit 7 high, stored bits where the direction is 1, else pin or 1.
  function automatic logic [31:0] bus_rd(input logic [7:0] dir, input logic [7:0] d, input logic [3:0] p);
    logic [7:0] lv;
    lv = {2'b11, p[3], p[2], p[1], 2'b11, p[0]};
    return {24'h0, 1'b1, (dir[6:0] & d[6:0]) | (~dir[6:0] & lv[6:0])};
  endfunction : bus_rd
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("BAD t=%0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  // One APB transfer; an idle cycle follows so no strobe is driven twice in one step.
  task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rchk(input logic [17:0] a, input logic [31:0] x, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(32'(e), 32'(ee));
    chk(r, ee ? 32'h0 : x);
  endtask : rchk
  task automatic rst(input logic [2:0] m, input int n);
    presetn <= 1'b0;
    mode <= m;
    repeat (n) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : rst
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // The whole run takes well under 2000 cycles; this cuts a hang short.
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
  initial begin
    logic hs;
    rst(3'h7, 20);
    rchk(BD, 32'h000000FF, 1'b0);
    rchk(BR, bus_rd(8'h80, 8'h80, 4'hA), 1'b0);
    wr(BD, 8'h7F);
    wr(BR, 8'h55);
    rchk(BR, 32'h000000D5, 1'b0);
    @(negedge pclk);
    chk(32'(bus_pin), 32'h5F);
    @(posedge pclk);
    wr(BD, 8'h46);
    rchk(BR, bus_rd(8'h46, 8'h55, 4'hA), 1'b0);
    chk(32'(bus_pin.oe), 32'h0);
    wr(UD, 8'h05);
    wr(UR, 8'h06);
    wr(PU, 8'h0F);
    rchk(UR, 32'h000000FE, 1'b0);
    chk(32'(upper_pin.oe), 32'h5);
    chk(32'(upper_pullup_en), 32'hA);
    $display("single-chip test done");
    hw_standby <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk(32'({upper_pin.oe, bus_pin.oe, upper_pullup_en}), 32'h0);
    @(posedge pclk);
    hw_standby <= 1'b0;
    @(posedge pclk);
    rchk(PU, 32'h000000F0, 1'b0);
    rchk(BR, bus_rd(8'h80, 8'h80, 4'hA), 1'b0);
    wr(BD, 8'h7F);
    rchk(BR, 32'h00000080, 1'b0);
    rchk({16'hFFCC, 2'b00}, 32'h0, 1'b1);
    rchk(BR + 18'h1, 32'h0, 1'b1);
    $display("standby and unmapped test done");
    rst(3'h5, 2);
    chk(32'(upper_pin.oe), 32'h0);
    wr(UD, 8'h0F);
    chk(32'(upper_pin), 32'h9F);
    wr(UD, 8'h03);
    wr(PU, 8'h0F);
    chk(32'({upper_pin.oe, upper_pullup_en}), 32'h3C);
    $display("ROM expanded test done");
    ext_bus <= 4'hE;
    for (int m = 1; m <= 3; m += 2) begin
      // Two strobe patterns so that any two swapped strobes differ in one of them.
      {store_strobe_n, read_strobe_n, address_strobe_n} <= (m == 1) ? 3'h3 : 3'h5;
      rst(m[2:0], 2);
      wr(PU, 8'h0F);
      chk(32'({upper_pin, upper_pullup_en}), 32'h9F0);
      chk(32'({bus_pin.out[3:1], bus_pin.oe[3:1]}), (m == 1) ? 32'h1F : 32'h2F);
      for (int i = 0; i < 8; i++) begin
        hs = i[0] | i[1];
        if (!(hs && i[2])) begin
          per_area_hold_enable <= i[0] ? 8'h00 : 8'hFF;
          hold_mode_select_hi <= i[1];
          wr(BD, {7'h0, i[2]});
          @(negedge pclk);
          chk(32'(bus_pin.oe[0]), hs ? 32'h0 : 32'(i[2]));
          chk(32'(hold_request_n), hs ? 32'h0 : 32'h1);
          @(posedge pclk);
        end
      end
    end
    $display("ROM-less expanded test done");
    end_sim();
  end
endmodule : acp_ports_tb_top
bind acp_ports acp_ports_monitor u_acp_ports_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .mode(mode),
  .hw_standby(hw_standby), .upper_addr(upper_addr), .store_strobe_n(store_strobe_n),
  .read_strobe_n(read_strobe_n), .address_strobe_n(address_strobe_n),
  .per_area_hold_enable(per_area_hold_enable), .hold_mode_select_hi(hold_mode_select_hi),
  .hold_request_n(hold_request_n), .upper_pin(upper_pin), .upper_pullup_en(upper_pullup_en),
  .bus_pin_in(bus_pin_in), .bus_pin(bus_pin));
